// *** design/usd_pkg.sv ***
// constants, types and register map of the serial data path
// How it works
// - transmit enable set: transmitter owns and drives the transmit pin
// - synchronous mode: transmit bits timed by the external serial clock
// - data write loads buffer; moves to shifter when idle or after stop
// - loaded shifter sends one whole frame at baud or external clock rate
// - character below eight bits: upper written bits ignored
// - buffer-empty flag high when buffer empty, cleared by data write
// - buffer-empty interrupt requested while enabled and flag set
// - transmit-complete set when frame out and buffer empty
// - transmit-complete cleared on interrupt service or by writing one
// - transmit-complete interrupt requested when enabled and flag set
// - parity enable: parity bit after last data bit, before stop
// - transmit disable takes effect once shifter and buffer empty
// - receive enable set: receiver owns the receive pin as input
// - synchronous mode: receiver uses external serial clock
// - frame starts at valid start bit; bits sampled until first stop
// - receiver ignores any second stop bit
// - first stop bit received: shifter moved into receive buffer
// - short characters read back with zero upper bits
// - receive-complete flag shows unread data; disable flushes it
// - receive disable stops reception at once, dropping data
// - frame: low start, data lsb first, high stop, idle high
package usd_pkg;
  localparam logic [11:0] USD_OFS_DATA   = 12'h000;
  localparam logic [11:0] USD_OFS_STATUS = 12'h004;
  localparam logic [11:0] USD_OFS_CTRL   = 12'h008;
  localparam logic [11:0] USD_OFS_FORMAT = 12'h00C;
  localparam logic [11:0] USD_OFS_BAUD   = 12'h010;
  // status bits
  localparam int USD_ST_RXC  = 7;
  localparam int USD_ST_TXC  = 6;
  localparam int USD_ST_TX_BUFFER_EMPTY_FLAG = 5;
  localparam int USD_ST_U2X  = 1;
  // control bits
  localparam int USD_CT_RX_COMPLETE_IRQ_ENABLE = 7;
  localparam int USD_CT_TX_COMPLETE_IRQ_ENABLE = 6;
  localparam int USD_CT_TX_BUFFER_EMPTY_IRQ_ENABLE = 5;
  localparam int USD_CT_RECEIVE_ENABLE  = 4;
  localparam int USD_CT_TRANSMIT_ENABLE  = 3;
  localparam int USD_CT_SZ2   = 2;
  localparam int USD_CT_RX_NINTH_BIT  = 1;
  localparam int USD_CT_TX_NINTH_BIT  = 0;
  // format bits
  localparam int USD_FM_SYNC = 6;
  localparam int USD_FM_PEN  = 5;
  localparam int USD_FM_PODD = 4;
  localparam int USD_FM_STOP2 = 3;
  localparam int USD_FM_SZ1  = 2;
  localparam int USD_FM_SZ0  = 1;
  localparam logic [7:0]  USD_FORMAT_RST = 8'h06;
  localparam logic [11:0] USD_BAUD_RST   = 12'h000;
  localparam logic [2:0]  USD_SZ_NINE    = 3'h7;
  localparam logic [4:0]  USD_OVS_NORM   = 5'h10;
  localparam logic [4:0]  USD_OVS_DBL    = 5'h08;
  localparam logic [3:0]  USD_DBITS_MIN  = 4'h5;
  localparam logic [3:0]  USD_DBITS_MAX  = 4'h9;
  localparam logic [31:0] USD_ZERO32     = 32'h0000_0000;

  typedef struct packed {
    logic       pen;
    logic       podd;
    logic       stop2;
    logic [3:0] dbits;
  } usd_fmt_t;

  typedef struct packed {
    logic       valid;
    logic [8:0] data;
  } usd_char_t;

  typedef enum logic [4:0] {
    USD_TX_IDLE  = 5'b00001,
    USD_TX_START = 5'b00010,
    USD_TX_DATA  = 5'b00100,
    USD_TX_PAR   = 5'b01000,
    USD_TX_STOP  = 5'b10000
  } usd_txst_t;

  typedef enum logic [3:0] {
    USD_RX_IDLE  = 4'b0001,
    USD_RX_START = 4'b0010,
    USD_RX_DATA  = 4'b0100,
    USD_RX_STOP  = 4'b1000
  } usd_rxst_t;

  // data bit count from the three-bit size code
  function automatic logic [3:0] usd_dbits(input logic [2:0] sz);
    case (sz)
      3'h0: usd_dbits = 4'h5;
      3'h1: usd_dbits = 4'h6;
      3'h2: usd_dbits = 4'h7;
      USD_SZ_NINE: usd_dbits = USD_DBITS_MAX;
      default: usd_dbits = 4'h8;
    endcase
  endfunction

  // keep only the low n bits of a nine-bit character
  function automatic logic [8:0] usd_mask(input logic [8:0] d,
                                          input logic [3:0] n);
    logic [8:0] m;
    m = 9'h1FF >> (4'h9 - n);
    usd_mask = d & m;
  endfunction
endpackage

// *** design/usd_tick.sv ***
// bit tick generator: baud divider or external clock edges
`timescale 1ns/1ps
module usd_tick #(
  parameter int DIV_W = 12
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // configuration
  input  wire logic [DIV_W-1:0] divider,
  input  wire logic             double_speed,
  input  wire logic             sync_mode,
  input  wire logic             xck_in,
  // tick outputs
  output logic                  tx_tick,
  output logic                  rx_sample
);
  import usd_pkg::*;
  logic [DIV_W-1:0] div_reg;
  logic [4:0]       ovs_reg;
  logic             x0_reg;
  logic             x1_reg;
  logic             x2_reg;
  logic             base;
  logic [4:0]       ovs_top;

  assign base    = (div_reg == '0);
  assign ovs_top = double_speed ? USD_OVS_DBL : USD_OVS_NORM;

  always_ff @(posedge ref_clk) begin
    if (rst || base) begin
      div_reg <= divider;
    end else begin
      div_reg <= div_reg - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ovs_reg <= 5'h00;
    end else if (base) begin
      ovs_reg <= (ovs_reg >= ovs_top - 5'h01) ? 5'h00 : ovs_reg + 5'h01;
    end
  end

  // only x1/x2 feed the edge detector; x0 is the first synchroniser stage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      x0_reg <= 1'b0;
      x1_reg <= 1'b0;
      x2_reg <= 1'b0;
    end else begin
      x0_reg <= xck_in;
      x1_reg <= x0_reg;
      x2_reg <= x1_reg;
    end
  end

  // change on rising, sample on falling external edge
  always_comb begin
    if (sync_mode) begin
      tx_tick   = x1_reg & ~x2_reg;
      rx_sample = ~x1_reg & x2_reg;
    end else begin
      tx_tick   = base && (ovs_reg == 5'h00);
      rx_sample = base && (ovs_reg == (ovs_top >> 1));
    end
  end
endmodule

// *** design/usd_top.sv ***
// serial transmit and receive data path with apb register access
`timescale 1ns/1ps
module usd_top #(
  parameter int DIV_W = 12
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // serial pins
  input  wire logic        rxd_in,
  output logic             txd_out,
  output logic             txd_oe,
  input  wire logic        xck_in,
  // interrupt requests and service
  output logic             irq_rx_complete,
  output logic             irq_tx_buffer_empty,
  output logic             irq_tx_complete,
  input  wire logic        tx_complete_ack
);
  import usd_pkg::*;

  logic [7:0]       status_reg;
  logic [7:0]       control_reg;
  logic [7:0]       format_reg;
  logic [DIV_W-1:0] baud_reg;
  usd_char_t        txbuf_reg;
  usd_char_t        rxbuf_reg;
  logic [8:0]       txsh_reg;
  logic [3:0]       txcnt_reg;
  logic             txpar_reg;
  logic             txstop2_reg;
  logic             txc_reg;
  logic             transmit_enable_eff_reg;
  usd_txst_t        txst_reg;
  usd_rxst_t        rxst_reg;
  logic [8:0]       rxsh_reg;
  logic [3:0]       rxcnt_reg;
  logic             rxd_s_reg;
  logic [31:0]      prdata_reg;
  logic             txd_reg;
  usd_fmt_t         fmt;
  logic             wr;
  logic             rd;
  logic             wr_data;
  logic             rd_data;
  logic             tx_tick;
  logic             rx_sample;
  logic             tx_load;
  logic             tx_last;
  logic             rx_done;
  logic             receive_enable;

  assign fmt.pen   = format_reg[USD_FM_PEN];
  assign fmt.podd  = format_reg[USD_FM_PODD];
  assign fmt.stop2 = format_reg[USD_FM_STOP2];
  assign fmt.dbits = usd_dbits({control_reg[USD_CT_SZ2],
                               format_reg[USD_FM_SZ1],
                               format_reg[USD_FM_SZ0]});
  assign receive_enable      = control_reg[USD_CT_RECEIVE_ENABLE];

  // zero-wait apb: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr      = psel && penable && pwrite;
  assign rd      = psel && penable && !pwrite;
  assign wr_data = wr && (paddr == USD_OFS_DATA);
  assign rd_data = rd && (paddr == USD_OFS_DATA);
  assign prdata  = prdata_reg;

  usd_tick #(
    .DIV_W       (DIV_W)
  ) u_tick (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .divider     (baud_reg),
    .double_speed(status_reg[USD_ST_U2X]),
    .sync_mode   (format_reg[USD_FM_SYNC]),
    .xck_in      (xck_in),
    .tx_tick     (tx_tick),
    .rx_sample   (rx_sample)
  );

  // configuration registers; software is expected to set them first
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      control_reg <= 8'h00;
      format_reg  <= USD_FORMAT_RST;
      baud_reg    <= USD_BAUD_RST[DIV_W-1:0];
      status_reg  <= 8'h00;
    end else begin
      if (wr && paddr == USD_OFS_CTRL) begin
        control_reg <= {pwdata[7:2], control_reg[USD_CT_RX_NINTH_BIT],
                        pwdata[USD_CT_TX_NINTH_BIT]};
      end else if (rx_done) begin
        control_reg[USD_CT_RX_NINTH_BIT] <= rxsh_reg[8];
      end
      if (wr && paddr == USD_OFS_FORMAT) begin
        format_reg <= pwdata[7:0];
      end
      if (wr && paddr == USD_OFS_BAUD) begin
        baud_reg <= pwdata[DIV_W-1:0];
      end
      // buffer-empty position is read-only; writes of it are ignored
      if (wr && paddr == USD_OFS_STATUS) begin
        status_reg[USD_ST_U2X] <= pwdata[USD_ST_U2X];
      end
    end
  end

  // loaded in the setup cycle so the data stand at the access edge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata_reg <= USD_ZERO32;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        USD_OFS_DATA:   prdata_reg <= {24'h0, rxbuf_reg.data[7:0]};
        USD_OFS_STATUS: prdata_reg <= {24'h0, rxbuf_reg.valid, txc_reg,
                                       !txbuf_reg.valid, 3'h0,
                                       status_reg[USD_ST_U2X], 1'b0};
        USD_OFS_CTRL:   prdata_reg <= {24'h0, control_reg};
        USD_OFS_FORMAT: prdata_reg <= {24'h0, format_reg};
        USD_OFS_BAUD:   prdata_reg <= {{(32-DIV_W){1'b0}}, baud_reg};
        default:        prdata_reg <= USD_ZERO32;
      endcase
    end
  end

  // transmit buffer; a write always wins over the move to the shifter
  // an idle shifter loads on a tick so the start bit lasts a full bit
  assign tx_load = txbuf_reg.valid &&
                   ((txst_reg == USD_TX_IDLE && tx_tick) || tx_last);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txbuf_reg <= '0;
    end else if (wr_data) begin
      txbuf_reg.valid <= 1'b1;
      txbuf_reg.data  <= usd_mask({control_reg[USD_CT_TX_NINTH_BIT], pwdata[7:0]},
                                  fmt.dbits);
    end else if (tx_load) begin
      txbuf_reg.valid <= 1'b0;
    end
  end

  // last stop bit ends on this tick
  assign tx_last = tx_tick && (txst_reg == USD_TX_STOP) &&
                   (!txstop2_reg || txcnt_reg != 4'h0);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txst_reg    <= USD_TX_IDLE;
      txsh_reg    <= 9'h000;
      txcnt_reg   <= 4'h0;
      txpar_reg   <= 1'b0;
      txstop2_reg <= 1'b0;
    end else if (tx_load && txst_reg == USD_TX_IDLE) begin
      txst_reg    <= USD_TX_START;
      txsh_reg    <= txbuf_reg.data;
      txpar_reg   <= ^txbuf_reg.data ^ fmt.podd;
      txstop2_reg <= fmt.stop2;
      txcnt_reg   <= 4'h0;
    end else if (tx_tick) begin
      case (txst_reg)
        USD_TX_START: begin
          txst_reg <= USD_TX_DATA;
        end
        USD_TX_DATA: begin
          txsh_reg  <= txsh_reg >> 1;
          txcnt_reg <= txcnt_reg + 4'h1;
          if (txcnt_reg == fmt.dbits - 4'h1) begin
            txst_reg  <= fmt.pen ? USD_TX_PAR : USD_TX_STOP;
            txcnt_reg <= 4'h0;
          end
        end
        USD_TX_PAR: begin
          txst_reg <= USD_TX_STOP;
        end
        USD_TX_STOP: begin
          txcnt_reg <= txcnt_reg + 4'h1;
          if (tx_last) begin
            // back-to-back frame when the buffer is already loaded
            txst_reg    <= txbuf_reg.valid ? USD_TX_START : USD_TX_IDLE;
            txsh_reg    <= txbuf_reg.data;
            txpar_reg   <= ^txbuf_reg.data ^ fmt.podd;
            txstop2_reg <= fmt.stop2;
            txcnt_reg   <= 4'h0;
          end
        end
        default: begin
          txst_reg <= USD_TX_IDLE;
        end
      endcase
    end
  end

  // serial output, registered
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txd_reg <= 1'b1;
    end else begin
      case (txst_reg)
        USD_TX_START: txd_reg <= 1'b0;
        USD_TX_DATA:  txd_reg <= txsh_reg[0];
        USD_TX_PAR:   txd_reg <= txpar_reg;
        default:      txd_reg <= 1'b1;
      endcase
    end
  end

  // pin ownership released only once nothing is left to send
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      transmit_enable_eff_reg <= 1'b0;
    end else if (control_reg[USD_CT_TRANSMIT_ENABLE]) begin
      transmit_enable_eff_reg <= 1'b1;
    end else if (txst_reg == USD_TX_IDLE && !txbuf_reg.valid) begin
      transmit_enable_eff_reg <= 1'b0;
    end
  end
  assign txd_oe  = transmit_enable_eff_reg;
  assign txd_out = txd_reg;

  // set wins over clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txc_reg <= 1'b0;
    end else if (tx_last && !txbuf_reg.valid) begin
      txc_reg <= 1'b1;
    end else if (tx_complete_ack ||
                 (wr && paddr == USD_OFS_STATUS && pwdata[USD_ST_TXC])) begin
      txc_reg <= 1'b0;
    end
  end

  assign irq_tx_buffer_empty = control_reg[USD_CT_TX_BUFFER_EMPTY_IRQ_ENABLE] &&
                               !txbuf_reg.valid;
  assign irq_tx_complete     = control_reg[USD_CT_TX_COMPLETE_IRQ_ENABLE] && txc_reg;
  assign irq_rx_complete     = control_reg[USD_CT_RX_COMPLETE_IRQ_ENABLE] && rxbuf_reg.valid;

  // receiver; pin is only looked at while enabled
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxd_s_reg <= 1'b1;
    end else begin
      rxd_s_reg <= receive_enable ? rxd_in : 1'b1;
    end
  end

  assign rx_done = receive_enable && rx_sample && rxst_reg == USD_RX_STOP;

  always_ff @(posedge ref_clk) begin
    if (rst || !receive_enable) begin
      rxst_reg  <= USD_RX_IDLE;
      rxsh_reg  <= 9'h000;
      rxcnt_reg <= 4'h0;
    end else if (rx_sample) begin
      case (rxst_reg)
        USD_RX_IDLE: begin
          // the low sample already lies inside the start bit
          if (!rxd_s_reg) begin
            rxst_reg  <= USD_RX_DATA;
            rxcnt_reg <= 4'h0;
            rxsh_reg  <= 9'h000;
          end
        end
        USD_RX_START: begin
          // a start bit that is high again was a glitch
          rxst_reg  <= rxd_s_reg ? USD_RX_IDLE : USD_RX_DATA;
          rxcnt_reg <= 4'h0;
          rxsh_reg  <= 9'h000;
        end
        USD_RX_DATA: begin
          rxsh_reg[rxcnt_reg] <= rxd_s_reg;
          rxcnt_reg           <= rxcnt_reg + 4'h1;
          if (rxcnt_reg == fmt.dbits - 4'h1 + {3'h0, fmt.pen}) begin
            rxst_reg <= USD_RX_STOP;
          end
        end
        USD_RX_STOP: begin
          rxst_reg <= USD_RX_IDLE;
        end
        default: begin
          rxst_reg <= USD_RX_IDLE;
        end
      endcase
    end
  end

  // new frame wins over a read in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst || !receive_enable) begin
      rxbuf_reg <= '0;
    end else if (rx_done) begin
      rxbuf_reg.valid <= 1'b1;
      rxbuf_reg.data  <= usd_mask(rxsh_reg, fmt.dbits);
    end else if (rd_data) begin
      rxbuf_reg.valid <= 1'b0;
    end
  end

  a_empty_after_wr: assert property (@(posedge ref_clk) disable iff (rst)
    wr_data |=> !irq_tx_buffer_empty && txbuf_reg.valid)
    else $error("buffer not full after data write");
  a_txc_set: assert property (@(posedge ref_clk) disable iff (rst)
    (tx_last && !txbuf_reg.valid) |=> txc_reg)
    else $error("tx complete not set");
  a_txc_clear: assert property (@(posedge ref_clk) disable iff (rst)
    (tx_complete_ack && !tx_last) |=> !txc_reg)
    else $error("tx complete not cleared");
  a_start_low: assert property (@(posedge ref_clk) disable iff (rst)
    (txst_reg == USD_TX_START) |=> !txd_out)
    else $error("start bit not low");
  a_idle_high: assert property (@(posedge ref_clk) disable iff (rst)
    (txst_reg == USD_TX_IDLE) [*2] |-> txd_out)
    else $error("idle line not high");
  a_oe_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (txd_oe && txst_reg != USD_TX_IDLE) |=> txd_oe)
    else $error("pin released mid frame");
  a_rx_flush: assert property (@(posedge ref_clk) disable iff (rst)
    !receive_enable |=> !rxbuf_reg.valid && rxst_reg == USD_RX_IDLE)
    else $error("receiver not flushed");
  a_rx_store: assert property (@(posedge ref_clk) disable iff (rst)
    rx_done |=> rxbuf_reg.valid ##1 ($stable(rxbuf_reg.data) || !receive_enable))
    else $error("frame not stored");
  a_load_move: assert property (@(posedge ref_clk) disable iff (rst)
    (tx_load && txst_reg == USD_TX_IDLE && !wr_data) |=>
      txst_reg == USD_TX_START && !txbuf_reg.valid)
    else $error("buffer not moved to shifter");
endmodule

// *** bench/usd_peer.sv ***
// remote serial peer: captures frames on the transmit line, sends on receive
`timescale 1ns/1ps
module usd_peer #(
  parameter int BIT_CLKS = 16
) (
  // clock
  input  wire logic ref_clk,
  // serial lines
  input  wire logic txd_line,
  output logic      rxd_line
);
  // idle line is high between frames
  initial rxd_line = 1'b1;

  // frame image: bit0 start, then data lsb first, parity, first stop
  // sampled mid-bit on the falling clock edge to stay clear of updates
  task automatic grab(input int nb, input bit par, output logic [11:0] fr);
    int i;
    fr = 12'h000;
    @(negedge txd_line);
    repeat (BIT_CLKS / 2) @(negedge ref_clk);
    for (i = 0; i < nb + par + 2; i++) begin
      if (i != 0) begin
        repeat (BIT_CLKS) @(negedge ref_clk);
      end
      fr[i] = txd_line;
    end
  endtask

  // send one frame: low start, data lsb first, one or two high stops
  task automatic put(input logic [8:0] d, input int nb, input bit s2);
    int i;
    for (i = 0; i < nb + 2 + s2; i++) begin
      rxd_line <= (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : 1'b1;
      repeat (BIT_CLKS) @(posedge ref_clk);
    end
  endtask
endmodule

// *** bench/usd_top_tb_top.sv ***
// self-checking bench for the serial data path
`timescale 1ns/1ps
module usd_top_tb_top;
  import usd_pkg::*;
  localparam logic [31:0] C_TX  = 32'h1 << USD_CT_TRANSMIT_ENABLE;
  localparam logic [31:0] C_RX  = 32'h1 << USD_CT_RECEIVE_ENABLE;
  localparam logic [31:0] C_UIE = 32'h1 << USD_CT_TX_BUFFER_EMPTY_IRQ_ENABLE;
  localparam logic [31:0] C_TIE = 32'h1 << USD_CT_TX_COMPLETE_IRQ_ENABLE;
  localparam logic [31:0] C_RIE = 32'h1 << USD_CT_RX_COMPLETE_IRQ_ENABLE;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        rxd_in;
  logic        txd_out;
  logic        txd_oe;
  logic        txd_line;
  logic        irq_rxc;
  logic        irq_ube;
  logic        irq_txc;
  logic        tx_complete_ack = 1'b0;
  logic        xck_run = 1'b0;
  logic [2:0]  xck_cnt = 3'h0;
  logic        external_serial_clock = 1'b0;
  int          err_count = 0;
  int          tests_run = 0;

  always #50 ref_clk = ~ref_clk;
  // external serial clock of sixteen system clocks, only while enabled
  always @(posedge ref_clk) begin
    if (xck_run) begin
      xck_cnt <= xck_cnt + 3'h1;
      if (xck_cnt == 3'h7) external_serial_clock <= ~external_serial_clock;
    end
  end
  // port pull-up holds the pin high once the transmitter lets go
  assign txd_line = txd_oe ? txd_out : 1'b1;

  usd_top u_usd_top (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(), .rxd_in(rxd_in),
    .txd_out(txd_out), .txd_oe(txd_oe), .xck_in(external_serial_clock),
    .irq_rx_complete(irq_rxc), .irq_tx_buffer_empty(irq_ube),
    .irq_tx_complete(irq_txc), .tx_complete_ack(tx_complete_ack));
  usd_peer u_usd_peer (.ref_clk(ref_clk), .txd_line(txd_line),
    .rxd_line(rxd_in));

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // read data stand from the setup edge and are taken at the access edge
  task automatic apb(input bit w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [11:0] frm(logic [8:0] d, int nb, bit pe,
                                      bit od);
    logic [11:0] f;
    logic        p;
    f = 12'h000;
    p = od;
    for (int i = 0; i < nb; i++) begin
      f[i+1] = d[i];
      p ^= d[i];
    end
    if (pe) f[nb+1] = p;
    f[nb+1+pe] = 1'b1;
    return f;
  endfunction

  task automatic t_reset;
    logic [31:0] v;
    apb(1'b0, USD_OFS_STATUS, 32'h0, v);
    chk(v, 32'h20);
    apb(1'b0, USD_OFS_FORMAT, 32'h0, v);
    chk(v, {24'h0, USD_FORMAT_RST});
    chk({31'h0, txd_oe}, 32'h0);
    $display("t_reset done");
  endtask

  task automatic t_tx_fmt;
    logic [2:0]  sz [5] = '{3'h3, 3'h0, 3'h2, 3'h7, 3'h1};
    int          nb [5] = '{8, 5, 7, 9, 6};
    bit          pn [5] = '{0, 1, 1, 0, 0};
    bit          od [5] = '{0, 0, 1, 0, 0};
    logic [8:0]  dt [5] = '{9'h0A5, 9'h0FF, 9'h0C3, 9'h15A, 9'h0E7};
    logic [11:0] fr;
    logic [31:0] v;
    wr(USD_OFS_BAUD, 32'h0);
    for (int k = 0; k < 5; k++) begin
      wr(USD_OFS_FORMAT, {26'h0, pn[k], od[k], 1'b0, sz[k][1:0], 1'b0});
      wr(USD_OFS_CTRL, {28'h0, 1'b1, sz[k][2], 1'b0, dt[k][8]});
      fork
        u_usd_peer.grab(nb[k], pn[k], fr);
        wr(USD_OFS_DATA, {24'h0, dt[k][7:0]});
      join
      chk({20'h0, fr}, {20'h0, frm(dt[k], nb[k], pn[k], od[k])});
      cyc(16);
    end
    wr(USD_OFS_STATUS, 32'h40);
    apb(1'b0, USD_OFS_STATUS, 32'h0, v);
    chk(v, 32'h20);
    $display("t_tx_fmt done");
  endtask

  task automatic t_b2b;
    logic [11:0] fa;
    logic [11:0] fb;
    logic [31:0] v;
    wr(USD_OFS_FORMAT, 32'h06);
    wr(USD_OFS_CTRL, C_TX | C_UIE | C_TIE);
    chk({31'h0, irq_ube}, 32'h1);
    fork
      begin
        u_usd_peer.grab(8, 1'b0, fa);
        u_usd_peer.grab(8, 1'b0, fb);
      end
      begin
        wr(USD_OFS_DATA, 32'h3C);
        do cyc(1); while (irq_ube !== 1'b1);
        wr(USD_OFS_DATA, 32'hC3);
        apb(1'b0, USD_OFS_STATUS, 32'h0, v);
        chk(v, 32'h00);
        chk({31'h0, irq_ube}, 32'h0);
        // disable with a frame pending: both frames must still leave
        wr(USD_OFS_CTRL, C_UIE | C_TIE);
      end
    join
    chk({20'h0, fa}, {20'h0, frm(9'h03C, 8, 0, 0)});
    chk({20'h0, fb}, {20'h0, frm(9'h0C3, 8, 0, 0)});
    chk({31'h0, txd_oe}, 32'h1);
    cyc(16);
    chk({31'h0, txd_oe}, 32'h0);
    apb(1'b0, USD_OFS_STATUS, 32'h0, v);
    chk(v, 32'h60);
    chk({31'h0, irq_txc}, 32'h1);
    tx_complete_ack <= 1'b1;
    cyc(1);
    tx_complete_ack <= 1'b0;
    apb(1'b0, USD_OFS_STATUS, 32'h0, v);
    chk(v, 32'h20);
    chk({31'h0, irq_txc}, 32'h0);
    $display("t_b2b done");
  endtask

  task automatic t_sync;
    logic [11:0] fr;
    wr(USD_OFS_FORMAT, 32'h46);
    wr(USD_OFS_CTRL, C_TX);
    xck_run <= 1'b1;
    fork
      u_usd_peer.grab(8, 1'b0, fr);
      wr(USD_OFS_DATA, 32'h96);
    join
    chk({20'h0, fr}, {20'h0, frm(9'h096, 8, 0, 0)});
    cyc(16);
    xck_run <= 1'b0;
    wr(USD_OFS_FORMAT, 32'h06);
    wr(USD_OFS_STATUS, 32'h40);
    $display("t_sync done");
  endtask

  task automatic t_rx;
    logic [31:0] v;
    wr(USD_OFS_CTRL, C_RX | C_RIE);
    wr(USD_OFS_FORMAT, 32'h08);
    u_usd_peer.put(9'h015, 5, 1'b1);
    apb(1'b0, USD_OFS_STATUS, 32'h0, v);
    chk(v, 32'hA0);
    chk({31'h0, irq_rxc}, 32'h1);
    apb(1'b0, USD_OFS_DATA, 32'h0, v);
    chk(v, 32'h15);
    apb(1'b0, USD_OFS_STATUS, 32'h0, v);
    chk(v, 32'h20);
    wr(USD_OFS_FORMAT, 32'h06);
    u_usd_peer.put(9'h0C3, 8, 1'b0);
    apb(1'b0, USD_OFS_STATUS, 32'h0, v);
    chk(v, 32'hA0);
    fork
      u_usd_peer.put(9'h000, 8, 1'b0);
      begin
        cyc(64);
        wr(USD_OFS_CTRL, 32'h0);
      end
    join
    apb(1'b0, USD_OFS_STATUS, 32'h0, v);
    chk(v, 32'h20);
    wr(USD_OFS_CTRL, C_RX);
    cyc(32);
    apb(1'b0, USD_OFS_STATUS, 32'h0, v);
    chk(v, 32'h20);
    $display("t_rx done");
  endtask

  task automatic conclude;
    $display("tests_run %0d err_count %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_tx_fmt();
    t_b2b();
    t_sync();
    t_rx();
    conclude();
  end

  // the tests need some 2000 cycles; a hang runs out well past that
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    conclude();
  end
endmodule
